// ### rtl/lsr_pkg.sv
// constants shared by the light sensor readout block
package lsr_pkg;
    // fixed 7-bit bus address, 1000100
    localparam logic [6:0] SLAVE_ADDR   = 7'h44;
    // register offsets
    localparam logic [2:0] OFS_OPCFG    = 3'h0;
    localparam logic [2:0] OFS_ALCTL    = 3'h1;
    localparam logic [2:0] OFS_THRHI    = 3'h2;
    localparam logic [2:0] OFS_THRLO    = 3'h3;
    localparam logic [2:0] OFS_LIGHTLO  = 3'h4;
    localparam logic [2:0] OFS_LIGHTHI  = 3'h5;
    localparam logic [2:0] OFS_TMRLO    = 3'h6;
    localparam logic [2:0] OFS_TMRHI    = 3'h7;
    // reset values
    localparam logic [7:0] RST_OPCFG    = 8'h00;
    localparam logic [7:0] RST_THRHI    = 8'hff;
    localparam logic [7:0] RST_THRLO    = 8'h00;
    // operation_config fields
    localparam int CONVERTER_ENABLE       = 7;
    localparam int CONVERTER_POWERDOWN    = 6;
    localparam int EXTERNAL_TIMING_SELECT = 5;
    localparam int DIODE_SELECT_HI        = 3;
    localparam int DIODE_SELECT_LO        = 2;
    localparam int WIDTH_SELECT_HI        = 1;
    localparam int WIDTH_SELECT_LO        = 0;
    localparam logic [1:0] DIODE_LIGHT  = 2'h2;
    // alarm_gain_control fields
    localparam int ALARM_FLAG             = 5;
    localparam int RANGE_SELECT_HI        = 3;
    localparam int RANGE_SELECT_LO        = 2;
    localparam int PERSIST_SELECT_HI      = 1;
    localparam int PERSIST_SELECT_LO      = 0;
    // command bits of the register address byte
    localparam int CMD_SYNC               = 7;
    localparam int CMD_CLEAR              = 6;
    // internal oscillator derived from the reference clock
    localparam int REF_KHZ                = 40000;
    localparam int OSC_LOW_KHZ            = 342;
    localparam int OSC_HIGH_KHZ           = 684;
    localparam logic [6:0] DIV_LOW      = 7'(REF_KHZ / OSC_LOW_KHZ);
    localparam logic [6:0] DIV_HIGH     = 7'(REF_KHZ / OSC_HIGH_KHZ);
    // persistence counts
    localparam logic [4:0] PERSIST_1    = 5'h01;
    localparam logic [4:0] PERSIST_4    = 5'h04;
    localparam logic [4:0] PERSIST_8    = 5'h08;
    localparam logic [4:0] PERSIST_16   = 5'h10;
    // synchroniser reset: charge low, sda and scl idle high
    localparam logic [2:0] SYNC_RST     = 3'h3;
endpackage

// ### rtl/lsr_sync.sv
// two-flop synchroniser for the pin inputs
`timescale 1ns/10ps
module lsr_sync (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic [2:0] i_async,
    output logic      [2:0] o_sync
);
    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] sync;
    } lsr_sync_t;

    lsr_sync_t st;
    lsr_sync_t next_st;

    // first stage is read by the second only
    always_comb begin
        next_st      = st;
        next_st.meta = i_async;
        next_st.sync = st.meta;
    end

    // both stages reset to the idle line levels
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= {lsr_pkg::SYNC_RST, lsr_pkg::SYNC_RST};
        end else begin
            st <= next_st;
        end
    end

    assign o_sync = st.sync;
endmodule

// ### rtl/lsr_integ.sv
// integration timer, charge counter and result capture
`timescale 1ns/10ps
module lsr_integ (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_run,
    input  wire logic        i_ext_mode,
    input  wire logic [1:0]  i_width,
    input  wire logic        i_fast,
    input  wire logic        i_sync,
    input  wire logic        i_charge,
    output logic             o_done,
    output logic      [15:0] o_light,
    output logic      [15:0] o_timer
);
    typedef struct packed {
        logic [6:0]  div;
        logic [15:0] ticks;
        logic [14:0] charge;
        logic        charge_q;
        logic        done;
        logic [15:0] light;
        logic [15:0] timer;
    } lsr_integ_t;

    lsr_integ_t st;
    lsr_integ_t next_st;
    logic       osc_tick;
    logic       end_int;

    // last oscillator tick of a 2^n window
    function automatic logic [15:0] last_tick(input logic [1:0] w);
        unique case (w)
            2'h0: last_tick = 16'hffff;
            2'h1: last_tick = 16'h0fff;
            2'h2: last_tick = 16'h00ff;
            2'h3: last_tick = 16'h000f;
        endcase
    endfunction

    // full scale of the signed (n-1) bit result
    function automatic logic [14:0] full_scale(input logic [1:0] w);
        unique case (w)
            2'h0: full_scale = 15'h7fff;
            2'h1: full_scale = 15'h07ff;
            2'h2: full_scale = 15'h007f;
            2'h3: full_scale = 15'h0007;
        endcase
    endfunction

    // oscillator, counters and end of integration
    always_comb begin
        next_st          = st;
        next_st.done     = 1'b0;
        next_st.charge_q = i_charge;
        osc_tick         = (st.div == 7'h00);
        end_int          = 1'b0;
        if (!i_run) begin
            next_st.div    = 7'h00;
            next_st.ticks  = 16'h0000;
            next_st.charge = 15'h0000;
        end else begin
            // range 3 and 4 double the oscillator
            if (osc_tick) begin
                next_st.div = (i_fast ? lsr_pkg::DIV_HIGH : lsr_pkg::DIV_LOW) - 7'h01; // RULE5
            end else begin
                next_st.div = st.div - 7'h01;
            end
            if (osc_tick && st.ticks != 16'hffff) begin
                next_st.ticks = st.ticks + 16'h0001;
            end
            if (i_charge && !st.charge_q && st.charge < full_scale(i_width)) begin
                next_st.charge = st.charge + 15'h0001; // RULE2
            end
            if (i_ext_mode) begin
                end_int = i_sync; // RULE4 RULE13
            end else begin
                end_int = osc_tick && (st.ticks == last_tick(i_width)); // RULE3
            end
            if (end_int) begin
                next_st.done   = 1'b1; // RULE19
                next_st.light  = {1'b0, st.charge}; // RULE2 RULE10
                next_st.timer  = (st.ticks == 16'hffff) ? st.ticks
                                 : st.ticks + {15'h0000, osc_tick}; // RULE10
                next_st.ticks  = 16'h0000;
                next_st.charge = 15'h0000;
            end
        end
    end

    // results and counters clear on reset
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_done  = st.done;
    assign o_light = st.light;
    assign o_timer = st.timer;
endmodule

// ### rtl/lsr_top.sv
// light sensor readout: bus slave, registers and alarm
// Overview of operation
// [RULE1] alarm pin only pulled low, never high
// [RULE2] light result is signed 15-bit count
// [RULE3] internal mode ends after 2^n oscillator ticks
// [RULE4] external mode period is between sync commands
// [RULE5] four gain ranges selectable by host
// [RULE6] alarm when count outside threshold window
// [RULE7] alarm only after persistent violation
// [RULE8] config registers hold until rewritten
// [RULE9] four read-only count bytes
// [RULE10] data holds latest result and timer
// [RULE11] answer bus address 1000100 only
// [RULE12] receiver pulls SDA low to acknowledge
// [RULE13] address bit 7 restarts integration; the code acts on it in external timing mode only
// [RULE14] address bit 6 clears the alarm
// [RULE15] eight registers, resets 00h, upper FFh
// [RULE16] alarm flag set on trigger, write-0 clears
// [RULE17] persistence codes give 1, 4, 8, 16
// [RULE18] threshold byte is upper byte, low zero
// [RULE19] light count refreshed each integration
// [RULE20] write: addr, reg, data; read: reg, restart
`timescale 1ns/10ps
module lsr_top (
    input  wire logic I_REF_CLK,
    input  wire logic I_RSTN,
    input  wire logic I_SCL,
    input  wire logic I_SDA,
    output logic      O_SDA_O,
    output logic      O_SDA_OE,
    input  wire logic I_CHARGE_PULSE,
    output logic      O_ALARM_N_O,
    output logic      O_ALARM_N_OE
);
    // bus slave sequencing states
    typedef enum logic [2:0] {
        IDLE,
        ADDR,
        REG,
        WDAT,
        ACK,
        RDAT,
        MACK,
        SKIP
    } lsr_bus_t;

    // all block state in one registered word
    typedef struct packed {
        lsr_bus_t   bus;
        lsr_bus_t   after;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [2:0] ptr;
        logic       scl_q;
        logic       sda_q;
        logic       sda_oe;
        logic       sync_cmd;
        logic [7:0] opcfg;
        logic       flag;
        logic [1:0] range;
        logic [1:0] persist;
        logic [7:0] thr_hi;
        logic [7:0] thr_lo;
        logic [4:0] hits;
    } lsr_top_t;

    // state, decoded line events and datapath nets
    lsr_top_t    st;
    lsr_top_t    next_st;
    logic [2:0]  pins;
    logic        scl;
    logic        sda;
    logic        scl_rise;
    logic        scl_fall;
    logic        start;
    logic        stop;
    logic        wr_en;
    logic        clr_cmd;
    logic [7:0]  rdata;
    logic [7:0]  alctl;
    logic        run;
    logic        done;
    logic [15:0] light;
    logic [15:0] timer;
    logic        outside;
    logic [4:0]  hits_inc;

    // persistence code to cycle count
    function automatic logic [4:0] persist_len(input logic [1:0] code);
        unique case (code)
            2'h0: persist_len = lsr_pkg::PERSIST_1; // RULE17
            2'h1: persist_len = lsr_pkg::PERSIST_4;
            2'h2: persist_len = lsr_pkg::PERSIST_8; // RULE7
            2'h3: persist_len = lsr_pkg::PERSIST_16;
        endcase
    endfunction

    // bus pins and charge pulses cross into the clock domain
    lsr_sync u_sync (
        .i_clk   (I_REF_CLK),
        .i_rst_n (I_RSTN),
        .i_async ({I_CHARGE_PULSE, I_SDA, I_SCL}),
        .o_sync  (pins)
    );

    // converter runs only when enabled, awake and on light diode
    assign run = st.opcfg[lsr_pkg::CONVERTER_ENABLE]
               & ~st.opcfg[lsr_pkg::CONVERTER_POWERDOWN]
               & (st.opcfg[lsr_pkg::DIODE_SELECT_HI:lsr_pkg::DIODE_SELECT_LO]
                  == lsr_pkg::DIODE_LIGHT);

    lsr_integ u_integ (
        .i_clk      (I_REF_CLK),
        .i_rst_n    (I_RSTN),
        .i_run      (run),
        .i_ext_mode (st.opcfg[lsr_pkg::EXTERNAL_TIMING_SELECT]),
        .i_width    (st.opcfg[lsr_pkg::WIDTH_SELECT_HI:lsr_pkg::WIDTH_SELECT_LO]),
        .i_fast     (st.range[1]),
        .i_sync     (st.sync_cmd),
        .i_charge   (pins[2]),
        .o_done     (done),
        .o_light    (light),
        .o_timer    (timer)
    );

    // bus line events
    assign scl      = pins[0];
    assign sda      = pins[1];
    assign scl_rise = scl & ~st.scl_q;
    assign scl_fall = ~scl & st.scl_q;
    assign start    = scl & st.scl_q & st.sda_q & ~sda;
    assign stop     = scl & st.scl_q & ~st.sda_q & sda;

    // threshold window, low byte of each bound is zero
    assign outside  = (light > {st.thr_hi, 8'h00})
                    | (light < {st.thr_lo, 8'h00}); // RULE6 RULE18
    assign hits_inc = (st.hits < lsr_pkg::PERSIST_16) ? st.hits + 5'h01 : st.hits;

    // control register read image, unused bits read 0
    assign alctl = {2'h0, st.flag, 1'b0, st.range, st.persist};

    // read data selected by the register pointer
    always_comb begin
        unique case (st.ptr)
            lsr_pkg::OFS_OPCFG:   rdata = st.opcfg;
            lsr_pkg::OFS_ALCTL:   rdata = alctl;
            lsr_pkg::OFS_THRHI:   rdata = st.thr_hi;
            lsr_pkg::OFS_THRLO:   rdata = st.thr_lo;
            lsr_pkg::OFS_LIGHTLO: rdata = light[7:0]; // RULE9
            lsr_pkg::OFS_LIGHTHI: rdata = light[15:8];
            lsr_pkg::OFS_TMRLO:   rdata = timer[7:0];
            lsr_pkg::OFS_TMRHI:   rdata = timer[15:8]; // RULE9
        endcase
    end

    // bus slave sequencing, register writes and alarm
    always_comb begin
        next_st          = st;
        next_st.scl_q    = scl;
        next_st.sda_q    = sda;
        next_st.sync_cmd = 1'b0;
        wr_en            = 1'b0;
        clr_cmd          = 1'b0;
        if (start) begin
            // start or repeated start, pointer kept
            next_st.bus    = ADDR;
            next_st.cnt    = 4'h0;
            next_st.sda_oe = 1'b0;
        end else if (stop) begin
            next_st.bus    = IDLE;
            next_st.sda_oe = 1'b0;
        end else begin
            unique case (st.bus)
                IDLE, SKIP: begin
                    next_st.sda_oe = 1'b0;
                end
                ADDR, REG, WDAT: begin
                    if (scl_rise && st.cnt != 4'h8) begin
                        next_st.sh  = {st.sh[6:0], sda};
                        next_st.cnt = st.cnt + 4'h1;
                    end else if (scl_fall && st.cnt == 4'h8) begin
                        next_st.cnt    = 4'h0;
                        next_st.bus    = ACK;
                        next_st.sda_oe = 1'b1; // RULE12
                        if (st.bus == ADDR) begin
                            if (st.sh[7:1] == lsr_pkg::SLAVE_ADDR) begin // RULE11
                                next_st.after = st.sh[0] ? RDAT : REG; // RULE20
                            end else begin
                                next_st.bus    = SKIP;
                                next_st.sda_oe = 1'b0;
                            end
                        end else if (st.bus == REG) begin
                            next_st.ptr      = st.sh[2:0];
                            next_st.sync_cmd = st.sh[lsr_pkg::CMD_SYNC]; // RULE13
                            clr_cmd          = st.sh[lsr_pkg::CMD_CLEAR]; // RULE14
                            next_st.after    = WDAT; // RULE20
                        end else begin
                            wr_en         = 1'b1;
                            next_st.after = WDAT;
                        end
                    end
                end
                ACK: begin
                    // release after the ninth clock, or start sending
                    if (scl_fall) begin
                        next_st.bus    = st.after;
                        next_st.sda_oe = 1'b0;
                        if (st.after == RDAT) begin
                            next_st.sh     = rdata;
                            next_st.sda_oe = ~rdata[7];
                            next_st.cnt    = 4'h1;
                        end
                    end
                end
                RDAT: begin
                    // shift out msb first on each falling edge
                    if (scl_fall) begin
                        if (st.cnt == 4'h8) begin
                            next_st.bus    = MACK;
                            next_st.sda_oe = 1'b0;
                        end else begin
                            next_st.sh     = {st.sh[6:0], 1'b0};
                            next_st.sda_oe = ~st.sh[6];
                            next_st.cnt    = st.cnt + 4'h1;
                        end
                    end
                end
                MACK: begin
                    // host acknowledge asks for another byte
                    if (scl_rise && sda) begin
                        next_st.bus = SKIP; // RULE12
                    end else if (scl_fall) begin
                        next_st.bus    = RDAT;
                        next_st.sh     = rdata;
                        next_st.sda_oe = ~rdata[7];
                        next_st.cnt    = 4'h1;
                    end
                end
            endcase
        end

        // register writes; read-only offsets ignore data
        if (wr_en) begin
            unique case (st.ptr)
                lsr_pkg::OFS_OPCFG: begin
                    next_st.opcfg = st.sh; // RULE8
                end
                lsr_pkg::OFS_ALCTL: begin
                    next_st.range   = st.sh[lsr_pkg::RANGE_SELECT_HI:lsr_pkg::RANGE_SELECT_LO];
                    next_st.persist = st.sh[lsr_pkg::PERSIST_SELECT_HI:lsr_pkg::PERSIST_SELECT_LO];
                    if (!st.sh[lsr_pkg::ALARM_FLAG]) begin
                        next_st.flag = 1'b0; // RULE16
                    end
                end
                lsr_pkg::OFS_THRHI: begin
                    next_st.thr_hi = st.sh;
                end
                lsr_pkg::OFS_THRLO: begin
                    next_st.thr_lo = st.sh;
                end
                default: begin
                    // count bytes keep their values
                end
            endcase
        end
        // command byte bit 6 clears the pending alarm
        if (clr_cmd) begin
            next_st.flag = 1'b0; // RULE14
        end

        // persistence count, set placed after clears so it wins
        if (done) begin
            if (outside) begin
                next_st.hits = hits_inc;
                if (hits_inc >= persist_len(st.persist)) begin
                    next_st.flag = 1'b1; // RULE6 RULE7 RULE16
                end
            end else begin
                next_st.hits = 5'h00;
            end
        end
    end

    // register the state; bus lines reset to idle high
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            st        <= '0; // RULE15
            st.scl_q  <= 1'b1;
            st.sda_q  <= 1'b1;
            st.opcfg  <= lsr_pkg::RST_OPCFG;
            st.thr_hi <= lsr_pkg::RST_THRHI; // RULE15
            st.thr_lo <= lsr_pkg::RST_THRLO;
        end else begin
            st <= next_st;
        end
    end

    // open-drain outputs never drive high
    assign O_SDA_O      = 1'b0;
    assign O_SDA_OE     = st.sda_oe;
    assign O_ALARM_N_O  = 1'b0; // RULE1
    assign O_ALARM_N_OE = st.flag; // RULE1
endmodule

// ### sim/lsr_checker_properties.sv
// pin protocol checks for the light sensor readout
`timescale 1ns/10ps
module lsr_checker (
    input wire logic I_REF_CLK,
    input wire logic I_RSTN,
    input wire logic I_SCL,
    input wire logic I_SDA,
    input wire logic O_SDA_O,
    input wire logic O_SDA_OE,
    input wire logic I_CHARGE_PULSE,
    input wire logic O_ALARM_N_O,
    input wire logic O_ALARM_N_OE
);
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RSTN);

    // open-drain pins only ever pull low
    a_alarm_drv_low: assert property (O_ALARM_N_O == 1'b0)
        else $error("alarm pin driven high");
    a_sda_drv_low: assert property (O_SDA_O == 1'b0)
        else $error("data pin driven high");
    // acknowledge and read bits move only while the bus clock is low
    a_ack_rise_low: assert property ($rose(O_SDA_OE) |-> !I_SCL)
        else $error("data pulled low while clock high");
    a_ack_stands: assert property ($rose(O_SDA_OE) |-> O_SDA_OE [*6])
        else $error("data pull released too early");
    a_oe_hold_high: assert property (
        I_SCL && $past(I_SCL) && $past(I_SCL, 2) && $past(I_SCL, 3) |-> $stable(O_SDA_OE))
        else $error("data pull changed while clock high");
    a_idle_release: assert property (I_SCL [*6] |-> !O_SDA_OE)
        else $error("data held low on idle bus");
    // alarm is cleared only by a bus access and otherwise stays
    a_clear_on_bus: assert property ($fell(O_ALARM_N_OE) |-> !$past(I_SCL, 2))
        else $error("alarm dropped without bus access");
    a_alarm_sticky: assert property (
        $past(O_ALARM_N_OE) && $past(I_SCL, 2) && $past(I_SCL, 3) |-> O_ALARM_N_OE)
        else $error("alarm dropped while bus clock high");
endmodule

bind lsr_top lsr_checker u_chk (
    .I_REF_CLK      (I_REF_CLK),
    .I_RSTN         (I_RSTN),
    .I_SCL          (I_SCL),
    .I_SDA          (I_SDA),
    .O_SDA_O        (O_SDA_O),
    .O_SDA_OE       (O_SDA_OE),
    .I_CHARGE_PULSE (I_CHARGE_PULSE),
    .O_ALARM_N_O    (O_ALARM_N_O),
    .O_ALARM_N_OE   (O_ALARM_N_OE)
);

// ### sim/lsr_host.sv
// bus host model for the light sensor readout
`timescale 1ns/10ps
module lsr_host (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_oe
);
    // idle bus: clock high, data released
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    // wait whole cycles, changes land after falling edges
    task automatic hold(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // one 200 ns bus clock, data read at end of high phase
    task automatic bit_x(input logic v, output logic r);
        o_sda_oe = ~v;
        hold(3);
        o_scl = 1'b1;
        hold(4);
        r = i_sda;
        o_scl = 1'b0;
        hold(1);
    endtask
    // start or repeated start
    task automatic start_c;
        o_sda_oe = 1'b0;
        hold(3);
        o_scl = 1'b1;
        hold(4);
        o_sda_oe = 1'b1;
        hold(4);
        o_scl = 1'b0;
        hold(1);
    endtask
    // stop, then idle
    task automatic stop_c;
        o_sda_oe = 1'b1;
        hold(3);
        o_scl = 1'b1;
        hold(4);
        o_sda_oe = 1'b0;
        hold(8);
    endtask
    // byte msb first, ninth clock left to the receiver
    task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], rx[i]);
        end
        bit_x(1'b1, a);
        ack = ~a;
    endtask
    // write: address, register byte, optional data byte
    task automatic wr(input logic [7:0] dev, input logic [7:0] ra, input logic has_d,
                      input logic [7:0] d, output logic [2:0] acks);
        logic [7:0] rx;
        start_c();
        byte_x(dev, rx, acks[2]);
        byte_x(ra, rx, acks[1]);
        acks[0] = acks[2];
        if (has_d) begin
            byte_x(d, rx, acks[0]);
        end
        stop_c();
    endtask
    // read: register byte, repeated start, one byte ended by no-acknowledge
    task automatic rd(input logic [7:0] ra, output logic [7:0] d, output logic [2:0] acks);
        logic a;
        start_c();
        byte_x({lsr_pkg::SLAVE_ADDR, 1'b0}, d, acks[2]);
        byte_x(ra, d, acks[1]);
        start_c();
        byte_x({lsr_pkg::SLAVE_ADDR, 1'b1}, d, acks[0]);
        byte_x(8'hff, d, a);
        stop_c();
    endtask
endmodule

// ### sim/testbench.sv
// self-checking bench for the light sensor readout
`timescale 1ns/10ps
module testbench;
    localparam logic [7:0] WR_ADDR = {lsr_pkg::SLAVE_ADDR, 1'b0};
    logic       clk;
    logic       rst_n = 1'b0;
    logic       scl;
    logic       host_oe;
    logic       sda;
    logic       dut_oe;
    logic       sda_o;
    logic       alarm_oe;
    logic       alarm_o;
    logic [2:0] cc = 3'h0;
    logic [2:0] acks;
    logic [7:0] v;
    int         error_cnt = 0;
    int         total_checks = 0;
    int         cyc = 0;
    int         n;
    int         m;
    int         d;
    int         t0;

    // open-drain data line with pull-up
    assign sda = ~(host_oe | dut_oe);

    lsr_top DUT (
        .I_REF_CLK      (clk),
        .I_RSTN         (rst_n),
        .I_SCL          (scl),
        .I_SDA          (sda),
        .O_SDA_O        (sda_o),
        .O_SDA_OE       (dut_oe),
        .I_CHARGE_PULSE (cc[2]),
        .O_ALARM_N_O    (alarm_o),
        .O_ALARM_N_OE   (alarm_oe)
    );
    lsr_host u_host (
        .i_clk    (clk),
        .i_sda    (sda),
        .o_scl    (scl),
        .o_sda_oe (host_oe)
    );

    // 40 MHz reference clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // charge pulses, one every eight cycles
    always @(negedge clk) begin
        cc <= cc + 3'h1;
    end
    // cycle count and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic final_report;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic in_rng(input logic [15:0] x, input int lo, input int hi);
        return (x >= lo) && (x <= hi);
    endfunction
    task automatic send(input logic [7:0] ra, input logic has_d, input logic [7:0] dv);
        u_host.wr(WR_ADDR, ra, has_d, dv, acks);
        check("write acks", 16'(acks), 16'h7);
    endtask
    task automatic rchk(input logic [7:0] ra, input logic [7:0] exp);
        u_host.rd(ra, v, acks);
        check("read acks", 16'(acks), 16'h7);
        check($sformatf("reg %0h", ra), 16'(v), 16'(exp));
    endtask

    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        repeat (4) @(negedge clk);
        // reset values, read-only and foreign address
        for (int i = 0; i < 8; i++) begin
            rchk(8'(i), (i == 2) ? 8'hff : 8'h00);
        end
        send(8'h04, 1'b1, 8'h5a);
        rchk(8'h04, 8'h00);
        u_host.wr(8'h8a, 8'h00, 1'b1, 8'h11, acks);
        check("foreign acks", 16'(acks), 16'h0);
        // settings hold; writing the flag high does not set it
        send(8'h00, 1'b1, 8'h4b);
        send(8'h03, 1'b1, 8'h12);
        send(8'h01, 1'b1, 8'h2f);
        rchk(8'h00, 8'h4b);
        rchk(8'h03, 8'h12);
        rchk(8'h01, 8'h0f);
        send(8'h03, 1'b1, 8'h00);
        send(8'h00, 1'b1, 8'h8b);
        // each range with its persistence count, 16-tick internal timing
        for (int i = 0; i < 4; i++) begin
            send(8'h02, 1'b1, 8'hff);
            send(8'h01, 1'b1, 8'(i * 5));
            repeat (2500) @(negedge clk);
            check("alarm in window", 16'(alarm_oe), 16'h0);
            send(8'h00, 1'b1, 8'h00);
            send(8'h02, 1'b1, 8'h00);
            send(8'h00, 1'b1, 8'h8b);
            m = (i == 0) ? 1 : (2 << i);
            d = (i < 2) ? int'(lsr_pkg::DIV_LOW) : int'(lsr_pkg::DIV_HIGH);
            n = 0;
            while (alarm_oe !== 1'b1 && n < 20000) begin
                @(negedge clk);
                n++;
            end
            v = 8'(in_rng(16'(n), (16 * m - 1) * d - 30, 16 * m * d + 10));
            check("alarm delay", 16'(v), 16'h1);
            rchk(8'h01, 8'h20 | 8'(i * 5));
        end
        rchk(8'h04, 8'h07);
        rchk(8'h05, 8'h00);
        rchk(8'h06, 8'h10);
        rchk(8'h07, 8'h00);
        // lower threshold, then clear by command byte
        send(8'h02, 1'b1, 8'hff);
        send(8'h03, 1'b1, 8'h01);
        send(8'h01, 1'b1, 8'h0c);
        repeat (1100) @(negedge clk);
        check("alarm below", 16'(alarm_oe), 16'h1);
        check("pin drive", 16'({sda_o, alarm_o}), 16'h0);
        send(8'h00, 1'b1, 8'h00);
        send(8'h40, 1'b0, 8'h00);
        check("alarm cleared", 16'(alarm_oe), 16'h0);
        rchk(8'h01, 8'h0c);
        // external timing between two restart commands
        send(8'h03, 1'b1, 8'h00);
        send(8'h00, 1'b1, 8'hab);
        send(8'h80, 1'b0, 8'h00);
        t0 = cyc;
        repeat (1160) @(negedge clk);
        send(8'h80, 1'b0, 8'h00);
        n = (cyc - t0) / int'(lsr_pkg::DIV_HIGH);
        u_host.rd(8'h06, v, acks);
        check("sync timer", 16'(in_rng(16'(v), n - 1, n + 1)), 16'h1);
        final_report();
    end
endmodule
